// ---- logic/dsa_pkg.sv ----
`default_nettype none
package dsa_pkg;
	// Reference and counting rates
	localparam int REF_HZ = 1000000;
	localparam int CNT_HZ = 500000;
	localparam int SEC_HZ = 1;
	localparam int MCLK_HZ = 40000000;
	// Divider counts in system clocks
	localparam int CNT_DIV = MCLK_HZ / CNT_HZ;
	localparam int HALF_SEC_DIV = MCLK_HZ / (2 * SEC_HZ);
	// Counter is a 20-bit binary count read out as six BCD digits, value 0..999999
	localparam int DIGITS = 6;
	localparam logic [19:0] CNT_PRESET = 20'h F1B30;
	localparam logic [19:0] CNT_WRAP = 20'h F423F;
	localparam logic [19:0] CNT_ZERO = 20'h 00000;
	// Serial control latch layout
	localparam int CTL_BITS = 8;
	localparam int CTL_SEL_LSB = 0;
	localparam int CTL_SEL_W = 3;
	localparam int CTL_SMOOTH = 3;
	localparam int CTL_REFTONE_N = 4;
	localparam int CTL_CAL_N = 5;
	localparam int CTL_SIDEBAND = 6;
	localparam int CTL_FREQMODE = 7;
	localparam logic [7:0] CTL_RESET = 8'h 30;
	// Sequencer state code for idle: all three latches high
	localparam logic [2:0] LATCH_IDLE = 3'h 7;
	typedef enum {
		DSA_IDLE, DSA_RAMP_UP, DSA_COUNT_UP, DSA_RAMP_DOWN, DSA_DONE, DSA_FREQ_WAIT, DSA_FREQ_CNT
	} dsa_state_e;
endpackage
`default_nettype wire

// ---- logic/dsa_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsa_sequencer #(
	parameter int HALF_SEC = dsa_pkg::HALF_SEC_DIV,
	parameter int COUNT_DIV = dsa_pkg::CNT_DIV
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Processor handshake pins
	input wire logic startN,
	input wire logic digitScan,
	output logic convDone,
	output logic [3:0] bcdDigit,
	// Ramp and counter
	input wire logic rampCmp,
	output logic rampDir,
	output logic countInhibit,
	output logic overflow,
	output logic [2:0] stateLatch,
	output logic refSecond,
	// Frequency path
	input wire logic pllIn,
	// Serial control
	input wire logic ctlClk,
	input wire logic ctlData,
	input wire logic ctlStrobe,
	output logic [2:0] inputSelect,
	output logic smoothingCtl,
	output logic refToneEnableN,
	output logic calN,
	output logic frequencyModeSelect,
	// Sideband oscillators
	input wire logic calToneSource,
	output logic usbEnable,
	output logic lsbEnable,
	output logic calTonePass
);
	import dsa_pkg::*;

	typedef struct packed {
		// Two-flop synchronisers, one per pin
		logic [1:0] startS;
		logic [1:0] scanS;
		logic [1:0] cmpS;
		logic [1:0] pllS;
		logic [1:0] cclkS;
		logic [1:0] cdatS;
		logic [1:0] cstbS;
		logic [1:0] toneS;
		// Previous synchronised level, for edge detection
		logic start1;
		logic scan1;
		logic cmp1;
		logic pll1;
		logic cclk1;
		logic cstb1;
		// Timebase: count-rate divider and half-second counter
		logic [7:0] div;
		logic [31:0] sec;
		logic secLevel;
		// Sequencer state and six-digit counter
		dsa_state_e st;
		logic [19:0] cnt;
		logic [2:0] digitIdx;
		// Host-visible status lines
		logic done;
		logic inhibit;
		logic dir;
		logic ovf;
		logic [2:0] latch;
		// Readout digit and serial control
		logic [3:0] digit;
		logic [CTL_BITS-1:0] shift;
		logic [CTL_BITS-1:0] ctl;
		// Sideband oscillator gates
		logic usb;
		logic lsb;
		logic tone;
	} dsa_s;

	dsa_s q, d;

	// Digit of a binary count, lowest digit first
	// Division chain is slow but only one digit is formed per scan
	function automatic logic [3:0] bcd_of(input logic [19:0] v, input logic [2:0] idx);
		logic [19:0] t;
		t = v;
		for (int i = 0; i < DIGITS; i++) begin
			if (3'(i) < idx) begin
				t = t / 20'h0000A;
			end
		end
		return 4'(t % 20'h0000A);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state: start from the current one, change only what moves
	always_comb begin
		d = q;
		// Every pin passes two flops before use
		// Edge flops read the second stage only; the first may be metastable
		d.startS = {q.startS[0], startN};
		d.scanS = {q.scanS[0], digitScan};
		d.cmpS = {q.cmpS[0], rampCmp};
		d.pllS = {q.pllS[0], pllIn};
		d.cclkS = {q.cclkS[0], ctlClk};
		d.cdatS = {q.cdatS[0], ctlData};
		d.cstbS = {q.cstbS[0], ctlStrobe};
		d.toneS = {q.toneS[0], calToneSource};
		d.start1 = q.startS[1];
		d.scan1 = q.scanS[1];
		d.cmp1 = q.cmpS[1];
		d.pll1 = q.pllS[1];
		d.cclk1 = q.cclkS[1];
		d.cstb1 = q.cstbS[1];

		d.div = (q.div == 8'(COUNT_DIV - 1)) ? 8'h00 : q.div + 8'h01;
		// 1 Hz reference: low half is the negative half-cycle
		// Limitation: the window is only as exact as HALF_SEC against mclk
		d.sec = (q.sec == 32'(HALF_SEC - 1)) ? 32'h0 : q.sec + 32'h1;
		if (q.sec == 32'(HALF_SEC - 1)) begin
			d.secLevel = ~q.secLevel;
		end

		// Counter increments while uninhibited; wrap flags overflow
		// Frequency mode counts sampled pin edges, so the pin stays below mclk/2
		// wrap at one million
		if (!q.inhibit && ((q.st == DSA_FREQ_CNT) ? (q.pllS[1] && !q.pll1) : (q.div == 8'h00))) begin
			if (q.cnt == CNT_WRAP) begin
				d.cnt = CNT_ZERO;
				d.ovf = 1'b1;
			end else begin
				d.cnt = q.cnt + 20'h00001;
			end
		end

		case (q.st)
			DSA_IDLE: begin
				d.inhibit = 1'b1;
				if (!q.startS[1] && q.start1) begin
					// Overflow stays visible from the last conversion until here
					d.ovf = 1'b0;
					d.digitIdx = 3'h0;
					if (q.ctl[CTL_FREQMODE]) begin
						d.st = DSA_FREQ_WAIT;
					end else begin
						d.dir = 1'b0;
						d.st = DSA_RAMP_UP;
					end
				end
			end
			DSA_RAMP_UP: begin
				if (q.cmpS[1] && !q.cmp1) begin
					d.inhibit = 1'b0;
					d.done = 1'b0;
					d.st = DSA_COUNT_UP;
				end
			end
			DSA_COUNT_UP: begin
				if (q.ovf) begin
					d.dir = 1'b1;
					d.st = DSA_RAMP_DOWN;
				end
			end
			DSA_RAMP_DOWN: begin
				if (!q.cmpS[1] && q.cmp1) begin
					d.inhibit = 1'b1;
					d.done = 1'b1;
					d.st = DSA_DONE;
				end
			end
			DSA_FREQ_WAIT: begin
				// Falling edge of the 1 Hz starts counting from zero
				if (q.sec == 32'(HALF_SEC - 1) && q.secLevel) begin
					d.cnt = CNT_ZERO;
					d.inhibit = 1'b0;
					d.done = 1'b0;
					d.st = DSA_FREQ_CNT;
				end
			end
			DSA_FREQ_CNT: begin
				// Stops when the reference turns positive again
				if (q.sec == 32'(HALF_SEC - 1) && !q.secLevel) begin
					d.inhibit = 1'b1;
					d.done = 1'b1;
					d.st = DSA_DONE;
				end
			end
			// Done is a pass-through; the host reads the counter from idle
			DSA_DONE: begin
				d.st = DSA_IDLE;
			end
			// Stray codes fall back to idle rather than lock up
			default: begin
				d.st = DSA_IDLE;
			end
		endcase

		// one digit per scan pulse
		// Scans while counting are refused so a running count is not disturbed
		if (q.scanS[1] && !q.scan1 && q.inhibit) begin
			d.digit = bcd_of(q.cnt, q.digitIdx);
			d.digitIdx = q.digitIdx + 3'h1;
			// preset after the last digit
			// Preset here, not at start, so the value can be read at leisure
			if (q.digitIdx == 3'(DIGITS - 1)) begin
				d.cnt = CNT_PRESET;
				d.digitIdx = 3'h0;
			end
		end

		// shift on clock edge, latch on strobe edge
		// Strobe copies the whole word, so pins never show a half-shifted word
		if (q.cclkS[1] && !q.cclk1) begin
			d.shift = {q.shift[CTL_BITS-2:0], q.cdatS[1]};
		end
		if (q.cstbS[1] && !q.cstb1) begin
			d.ctl = q.shift;
		end

		if (!q.ctl[CTL_CAL_N]) begin
			d.usb = 1'b0;
			d.lsb = 1'b0;
			d.tone = q.toneS[1];
		end else begin
			d.usb = q.ctl[CTL_SIDEBAND];
			d.lsb = ~q.ctl[CTL_SIDEBAND];
			d.tone = 1'b1;
		end

		// latch code follows the next state, so its pins come from a flop
		d.latch = (d.st == DSA_IDLE) ? LATCH_IDLE : {d.dir, d.inhibit, d.done};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register the whole state; reset lands in idle with counter preset
	// Synchronous reset only; every reset value is a constant
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.startS <= 2'h3;
			q.start1 <= 1'b1;
			q.secLevel <= 1'b1;
			q.st <= DSA_IDLE;
			q.cnt <= CNT_PRESET;
			q.done <= 1'b1;
			q.inhibit <= 1'b1;
			q.dir <= 1'b1;
			q.ctl <= CTL_RESET;
			q.tone <= 1'b1;
			// Sideband gates agree with the reset control word
			q.usb <= CTL_RESET[CTL_SIDEBAND];
			q.lsb <= ~CTL_RESET[CTL_SIDEBAND];
			q.latch <= LATCH_IDLE;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign convDone = q.done;
	assign bcdDigit = q.digit;
	assign rampDir = q.dir;
	assign countInhibit = q.inhibit;
	assign overflow = q.ovf;
	// Latch pins are a flop of their own, updated with the state
	assign stateLatch = q.latch;
	assign refSecond = q.secLevel;
	assign inputSelect = q.ctl[CTL_SEL_LSB +: CTL_SEL_W];
	assign smoothingCtl = q.ctl[CTL_SMOOTH];
	assign refToneEnableN = q.ctl[CTL_REFTONE_N];
	assign calN = q.ctl[CTL_CAL_N];
	assign frequencyModeSelect = q.ctl[CTL_FREQMODE];
	assign usbEnable = q.usb;
	assign lsbEnable = q.lsb;
	assign calTonePass = q.tone;
endmodule
`default_nettype wire

// ---- tb/dsa_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsa_host_model (
	// Bench commands
	input wire logic mclk,
	input wire logic goStart,
	input wire logic goScan,
	// Processor pins
	output logic startN,
	output logic digitScan
);
	always @(posedge mclk) begin
		startN <= !goStart;
		digitScan <= goScan;
	end
endmodule
`default_nettype wire

// ---- tb/dsa_sequencer_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsa_sequencer_asserts (
	// Clock and pins
	input wire logic mclk,
	input wire logic rst,
	input wire logic startN,
	input wire logic rampCmp,
	input wire logic convDone,
	input wire logic rampDir,
	input wire logic countInhibit,
	input wire logic overflow,
	input wire logic [2:0] stateLatch,
	input wire logic refSecond,
	input wire logic calN,
	input wire logic calToneSource,
	input wire logic usbEnable,
	input wire logic lsbEnable,
	input wire logic frequencyModeSelect
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Conversion steps; pins pass a 2-flop sync, hence 3 to 5 cycles
	sequence idleStart; $fell(startN) && stateLatch == 3'h7 && !frequencyModeSelect; endsequence
	sequence cmpRise; $rose(rampCmp) && !rampDir && countInhibit; endsequence
	a_start_ramp: assert property (idleStart |-> ##[3:5] !rampDir) else $error("ramp not started");
	a_cmp_release: assert property (cmpRise |-> ##[3:5] !countInhibit && !convDone)
		else $error("count not released");
	a_done_pair: assert property (!frequencyModeSelect |-> convDone == countInhibit)
		else $error("done and inhibit differ");
	a_busy_latch: assert property (!rampDir || !convDone |-> stateLatch != 3'h7)
		else $error("idle code while busy");
	a_ramp_back: assert property ($rose(overflow) |-> ##[0:2] rampDir) else $error("no ramp down");
	a_freq_wait: assert property ($fell(convDone) && frequencyModeSelect |-> !refSecond)
		else $error("freq count off phase");
	a_cal_off: assert property (!calN && !$past(calN) |-> !usbEnable && !lsbEnable)
		else $error("oscillator on in cal");
	a_sb_pick: assert property (calN && $past(calN) && calToneSource |-> usbEnable != lsbEnable)
		else $error("sideband pick wrong");
endmodule
bind dsa_sequencer dsa_sequencer_asserts u_chk (.mclk(mclk), .rst(rst), .startN(startN), .rampCmp(rampCmp),
	.convDone(convDone), .rampDir(rampDir), .countInhibit(countInhibit), .overflow(overflow),
	.stateLatch(stateLatch), .refSecond(refSecond), .calN(calN), .calToneSource(calToneSource),
	.usbEnable(usbEnable), .lsbEnable(lsbEnable), .frequencyModeSelect(frequencyModeSelect));
`default_nettype wire

// ---- tb/test_dual_slope_adc_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_dual_slope_adc_sequencer;
	import dsa_pkg::*;
	logic mclk = 0, rst = 1, goStart = 0, goScan = 0, rampCmp = 0, pllIn = 0;
	logic ctlClk = 0, ctlData = 0, ctlStrobe = 0, calToneSource = 1;
	logic startN, digitScan, convDone, rampDir, countInhibit, overflow, refSecond, smoothingCtl;
	logic refToneEnableN, calN, frequencyModeSelect, usbEnable, lsbEnable, calTonePass;
	logic [3:0] bcdDigit;
	logic [2:0] stateLatch, inputSelect;
	logic [7:0] ctlQ[$];
	logic [31:0] rng = 32'h2172;
	int n_fail = 0, checked = 0, cyc = 0, mdl = 0;
	localparam int CDIV = 2;
	dsa_sequencer #(.HALF_SEC(100), .COUNT_DIV(CDIV)) DUT (.mclk(mclk), .rst(rst), .startN(startN),
		.digitScan(digitScan), .convDone(convDone), .bcdDigit(bcdDigit), .rampCmp(rampCmp), .rampDir(rampDir),
		.countInhibit(countInhibit), .overflow(overflow), .stateLatch(stateLatch), .refSecond(refSecond),
		.pllIn(pllIn), .ctlClk(ctlClk), .ctlData(ctlData), .ctlStrobe(ctlStrobe), .inputSelect(inputSelect),
		.smoothingCtl(smoothingCtl), .refToneEnableN(refToneEnableN), .calN(calN),
		.frequencyModeSelect(frequencyModeSelect), .calToneSource(calToneSource), .usbEnable(usbEnable),
		.lsbEnable(lsbEnable), .calTonePass(calTonePass));
	dsa_host_model host (.mclk(mclk), .goStart(goStart), .goScan(goScan), .startN(startN), .digitScan(digitScan));
	always #12.5 mclk = !mclk;
	// Frequency source, reference edge count and hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc % 5 == 0) begin
			pllIn <= !pllIn;
			if (!pllIn && convDone === 1'b0) mdl++;
		end
		if (cyc == 40000) begin
			n_fail++;
			print_verdict;
		end
	end
	////////////////////////////////////////////////////////////
	task tick(int n);
		repeat (n) @(posedge mclk);
	endtask
	task chk(string name, logic [19:0] seen, logic [19:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	function logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Serial control word, MSB first, slow enough for the pin sync
	task send(logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			ctlData <= b[i];
			tick(4);
			ctlClk <= 1;
			tick(4);
			ctlClk <= 0;
		end
		ctlStrobe <= 1;
		tick(4);
		ctlStrobe <= 0;
		tick(6);
		ctlQ.push_back(b);
	endtask
	task pulseStart;
		goStart <= 1;
		tick(3);
		goStart <= 0;
	endtask
	// Six scans, lowest digit first
	task readout(output int v);
		int m;
		v = 0;
		m = 1;
		for (int j = 0; j < 6; j++) begin
			goScan <= 1;
			tick(4);
			goScan <= 0;
			tick(6);
			v += bcdDigit * m;
			m *= 10;
		end
	endtask
	task print_verdict;
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] b;
		int v, n;
		tick(10);
		rst <= 0;
		tick(2);
		chk("idle", {convDone, countInhibit, rampDir, stateLatch, usbEnable, lsbEnable}, 8'hFD);
		chk("ctl", {frequencyModeSelect, 1'b0, calN, refToneEnableN, smoothingCtl, inputSelect}, CTL_RESET);
		// Random control words, calibrate alternating
		for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			calToneSource <= i[0] ? 1'b1 : rng[8];
			send({rng[7:6], i[0], rng[4:0]});
			b = ctlQ.pop_front();
			chk("ctl", {frequencyModeSelect, 1'b0, calN, refToneEnableN, smoothingCtl, inputSelect}, {b[7], 1'b0, b[5:0]});
			chk("osc", {usbEnable, lsbEnable}, b[5] ? {b[6], !b[6]} : 2'b00);
			chk("tone", calTonePass, b[5] ? 1'b1 : calToneSource);
		end
		// Conversion start, count release, refused restart, reset mid-count
		calToneSource <= 1;
		send(8'h30);
		pulseStart;
		tick(6);
		chk("ramp", rampDir, 0);
		rampCmp <= 1;
		tick(6);
		chk("count", {countInhibit, convDone}, 0);
		pulseStart;
		tick(8);
		chk("busy", {rampDir, convDone, stateLatch == 3'h7}, 0);
		rst <= 1;
		rampCmp <= 0;
		tick(2);
		rst <= 0;
		tick(2);
		chk("idle", {convDone, countInhibit, rampDir, stateLatch}, 6'h3F);
		// Frequency mode: waits for low half, then reads and presets
		send(8'hB0);
		pulseStart;
		mdl = 0;
		for (int k = 0; k < 400 && convDone !== 1'b0; k++) tick(1);
		chk("phase", {convDone, refSecond}, 0);
		for (int k = 0; k < 400 && convDone !== 1'b1; k++) tick(1);
		chk("done", {convDone, countInhibit}, 2'h3);
		readout(v);
		chk("freq", v >= mdl - 1 && v <= mdl + 1, 1);
		readout(v);
		chk("preset", v, CNT_PRESET);
		// Full conversion: ramp up, wrap after 10000 counts, ramp down, read the count
		send(8'h30);
		pulseStart;
		tick(6);
		rampCmp <= 1;
		for (n = 0; n < 25000 && overflow !== 1'b1; n++) tick(1);
		chk("wrap", n >= 10000 * CDIV && n <= 10000 * CDIV + 10, 1);
		tick(4);
		chk("down", {rampDir, countInhibit, convDone, overflow}, 4'h9);
		tick(196);
		rampCmp <= 0;
		for (n = 0; n < 50 && convDone !== 1'b1; n++) tick(1);
		chk("stop", {convDone, countInhibit}, 2'h3);
		readout(v);
		chk("conv", v >= 203 / CDIV - 3 && v <= 203 / CDIV + 3, 1);
		print_verdict;
	end
endmodule
`default_nettype wire
